// ==== design/servo_pkg.sv ====
// Shared constants, register map and types for the servo axis control block
package servo_pkg;
   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_NS = 40;
   localparam int SAMPLE_NS = 120;
   localparam int READ_NS = 6720;
   localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;
   localparam int READ_CYC = READ_NS / CLK_NS;
   localparam int LED_HOLD_MS = 100;
   localparam int LED_HOLD_CYC = LED_HOLD_MS * (1000000 / CLK_NS);

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_MASK = 8'h08;
   localparam logic [7:0] REG_STATE = 8'h0c;
   localparam logic [7:0] REG_TUNES = 8'h10;

   localparam int CTRL_IGNORE = 0;
   localparam int CTRL_HEATER = 1;
   localparam int CTRL_SHUTDOWN = 2;
   localparam int CTRL_RANGE = 3;
   localparam int CTRL_DLDONE = 8;
   localparam logic [4:0] CTRL_RESET = 5'h01;
   localparam logic [15:0] TUNES_RESET = 16'h0000;

   localparam int EV_OVERCUR = 0;
   localparam int EV_OVERTEMP = 2;
   localparam int EV_OVERVOLT = 4;
   localparam int EV_BOARD = 6;
   localparam int EV_DLDONE = 7;
   localparam int EV_W = 8;

   localparam int ST_ENABLED = 0;
   localparam int ST_FAULT = 2;
   localparam int ST_HEALTH = 4;
   localparam int ST_READY = 6;
   localparam int ST_SYNC = 8;
   localparam int ST_TUNE_X = 12;
   localparam int ST_TUNE_Y = 16;

   // Board temperature warning threshold, degrees C
   localparam logic [7:0] BOARD_WARN_C = 8'h4b;

   // Command over-voltage limits in mV per range code
   localparam logic [15:0] OV_MAX_3 = 16'h0cb2;
   localparam logic [15:0] OV_MAX_5 = 16'h13f6;
   localparam logic [15:0] OV_MAX_8 = 16'h2094;
   localparam logic [15:0] OV_MAX_10 = 16'h27d8;

   typedef enum logic [2:0] {
      AX_OFF = 3'b001,
      AX_ON = 3'b010,
      AX_TRIPPED = 3'b100
   } axis_state_t;

   function automatic logic [15:0] ov_limit(input logic [1:0] range);
      case (range)
         2'h0: ov_limit = OV_MAX_3;
         2'h1: ov_limit = OV_MAX_5;
         2'h2: ov_limit = OV_MAX_8;
         default: ov_limit = OV_MAX_10;
      endcase
   endfunction
endpackage

// ==== design/axis_if.sv ====
// Per-axis enable handshake between the top level and the axis sequencer
`timescale 1ns/1ps
interface axis_if;
   logic en_pin;
   logic fault;
   logic ignore;
   logic enabled;
   modport top (output en_pin, output fault, output ignore, input enabled);
   modport axis (input en_pin, input fault, input ignore, output enabled);
endinterface // axis_if

// ==== design/axis_enable.sv ====
// Edge-armed enable sequencer for one servo axis
`timescale 1ns/1ps
module axis_enable
   import servo_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Axis handshake
   axis_if.axis a
);
   axis_state_t state;
   logic pin_prev;
   logic fall;

   // Reset to high so a pin already low at start counts as a fall and arms the axis
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_prev <= 1'b1;
      end else begin
         pin_prev <= a.en_pin;
      end
   end

   assign fall = pin_prev & ~a.en_pin;

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= AX_OFF;
      end else begin
         case (state)
            AX_OFF: begin
               if (!a.fault && (a.ignore || fall)) begin
                  state <= AX_ON;
               end
            end
            AX_ON: begin
               if (a.fault) begin
                  state <= AX_TRIPPED;
               end else if (!a.ignore && a.en_pin) begin
                  state <= AX_OFF;
               end
            end
            AX_TRIPPED: begin
               // With ignore clear, re-arm needs the pin strobed high first, then a fall
               if (a.ignore && !a.fault) begin
                  state <= AX_ON;
               end else if (!a.ignore && a.en_pin) begin
                  state <= AX_OFF;
               end
            end
            default: state <= AX_OFF;
         endcase
      end
   end

   assign a.enabled = (state == AX_ON);

   fault_disables_a: assert property (@(posedge clk) disable iff (rst)
      a.fault |=> !a.enabled)
      else $error("axis stayed enabled during a fault");
   high_disables_a: assert property (@(posedge clk) disable iff (rst)
      (!a.ignore && a.en_pin) |=> !a.enabled)
      else $error("axis enabled while enable pin high");
   level_no_arm_a: assert property (@(posedge clk) disable iff (rst)
      (!a.ignore && !a.enabled && !fall) |=> !a.enabled)
      else $error("axis armed without a falling edge");
   rearm_c: cover property (@(posedge clk) disable iff (rst)
      state == AX_TRIPPED ##[1:20] a.enabled);
endmodule // axis_enable

// ==== design/sync_sampler.sv ====
// Debounce, latch and alternate read timing for the tune-select inputs
`timescale 1ns/1ps
module sync_sampler
   import servo_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Sync pins and latched value
   input wire logic [3:0] sync_in,
   output logic [3:0] latched,
   // Read timing
   output logic read_pulse,
   output logic read_axis
);
   logic [1:0] samp_cnt;
   logic [7:0] read_cnt;
   logic [3:0] prev_sample;
   logic samp_tick;

   assign samp_tick = (samp_cnt == 2'(SAMPLE_CYC - 1));

   always_ff @(posedge clk) begin
      if (rst) begin
         samp_cnt <= 2'h0;
      end else if (samp_tick) begin
         samp_cnt <= 2'h0;
      end else begin
         samp_cnt <= samp_cnt + 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prev_sample <= 4'h0;
         latched <= 4'h0;
      end else if (samp_tick) begin
         prev_sample <= sync_in;
         if (sync_in == prev_sample) begin
            latched <= sync_in;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         read_cnt <= 8'h00;
         read_pulse <= 1'b0;
         read_axis <= 1'b1;
      end else begin
         read_pulse <= (read_cnt == 8'(READ_CYC - 1));
         if (read_cnt == 8'(READ_CYC - 1)) begin
            read_cnt <= 8'h00;
            read_axis <= ~read_axis;
         end else begin
            read_cnt <= read_cnt + 8'h01;
         end
      end
   end

   latch_stable_a: assert property (@(posedge clk) disable iff (rst)
      (latched != $past(latched)) |-> ($past(samp_tick)
         && latched == $past(sync_in) && latched == $past(prev_sample)))
      else $error("sync latch took an unstable sample");
   read_period_a: assert property (@(posedge clk) disable iff (rst)
      read_pulse |=> !read_pulse [*8])
      else $error("sync read pulses too close together");
endmodule // sync_sampler

// ==== design/servo_axis_control_status.sv ====
// Two-axis servo control and status: enables, health, ready, sync, LED
`timescale 1ns/1ps

module servo_axis_control_status
   import servo_pkg::*;
#(
   parameter int LED_HOLD = LED_HOLD_CYC
)
(
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // Register port
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   output logic IRQ,
   // Enable inputs, one per axis (bit 0 X, bit 1 Y)
   input wire logic [1:0] EN_PIN,
   // Tune-select sync inputs
   input wire logic [3:0] SYNC_PIN,
   // Fault monitors
   input wire logic [1:0] COIL_TEMP_OK,
   input wire logic [1:0] COIL_CUR_OK,
   input wire logic [1:0] CASE_TEMP_OK,
   input wire logic [1:0] CASE_IN_BAND,
   input wire logic BOARD_TEMP_OK,
   input wire logic [7:0] BOARD_TEMP,
   input wire logic [1:0][15:0] CMD_MAG,
   // Open-drain health outputs
   input wire logic [1:0] HEALTH_I,
   output logic [1:0] HEALTH_O,
   output logic [1:0] HEALTH_OE,
   // Open-drain ready outputs
   input wire logic [1:0] READY_I,
   output logic [1:0] READY_O,
   output logic [1:0] READY_OE,
   // Indicator and active tunes
   output logic LED,
   output logic [3:0] TUNE_X,
   output logic [3:0] TUNE_Y
);
   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   logic [4:0] ctrl;
   logic [EV_W-1:0] stat;
   logic [EV_W-1:0] mask;
   logic [15:0] tunes;
   logic dl_pulse;
   logic [EV_W-1:0] next_stat;
   logic [EV_W-1:0] next_mask;
   logic [31:0] next_rdata;

   logic ignore_en;
   logic heater_use;
   logic shutdown_en;
   logic [1:0] range;

   assign ignore_en = ctrl[CTRL_IGNORE];
   assign heater_use = ctrl[CTRL_HEATER];
   assign shutdown_en = ctrl[CTRL_SHUTDOWN];
   assign range = ctrl[CTRL_RANGE +: 2];

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         ctrl <= CTRL_RESET;
         mask <= {EV_W{1'b0}};
         tunes <= TUNES_RESET;
      end else if (WR) begin
         case (ADDR)
            REG_CTRL: ctrl <= WDATA[4:0];
            REG_MASK: mask <= WDATA[EV_W-1:0];
            REG_TUNES: tunes <= WDATA[15:0];
            default: ;
         endcase
      end
   end

   // Writing one to the download-done bit marks a finished download
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         dl_pulse <= 1'b0;
      end else begin
         dl_pulse <= WR && (ADDR == REG_CTRL) && WDATA[CTRL_DLDONE];
      end
   end

   // ----------------------------------------------------------------------
   // Health and fault evaluation
   // ----------------------------------------------------------------------
   logic board_hot;
   logic [1:0] health_ok;
   logic [1:0] over_cur;
   logic [1:0] over_temp;
   logic [1:0] over_volt;
   logic [1:0] fault;
   logic [1:0] enabled;

   assign board_hot = BOARD_TEMP > BOARD_WARN_C;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_axis
         axis_if ax ();

         assign health_ok[g] = COIL_TEMP_OK[g] && COIL_CUR_OK[g]
            && BOARD_TEMP_OK
            && (!heater_use || (CASE_TEMP_OK[g] && CASE_IN_BAND[g]));
         assign over_cur[g] = !COIL_CUR_OK[g];
         assign over_temp[g] = !COIL_TEMP_OK[g];
         assign over_volt[g] = CMD_MAG[g] > ov_limit(range);
         assign fault[g] = over_cur[g] || over_temp[g] || over_volt[g]
            || (shutdown_en && board_hot);

         assign ax.en_pin = EN_PIN[g];
         assign ax.fault = fault[g];
         assign ax.ignore = ignore_en;
         assign enabled[g] = ax.enabled;

         axis_enable u_axis (
            .clk (SYS_CLK),
            .rst (RST),
            .a (ax.axis)
         );
      end
   endgenerate

   // Open-drain pins only ever pull low; release means a failed health check or an axis not ready
   assign HEALTH_O = 2'h0;
   assign READY_O = 2'h0;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         HEALTH_OE <= 2'h0;
         READY_OE <= 2'h0;
      end else begin
         HEALTH_OE <= health_ok;
         READY_OE <= enabled & ~fault;
      end
   end

   // ----------------------------------------------------------------------
   // Events, status and interrupt
   // ----------------------------------------------------------------------
   logic [EV_W-2:0] cond;
   logic [EV_W-2:0] cond_prev;
   logic [EV_W-1:0] events;

   assign cond = {board_hot, over_volt, over_temp, over_cur};
   assign events = {dl_pulse, cond & ~cond_prev};

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         cond_prev <= {(EV_W-1){1'b0}};
      end else begin
         cond_prev <= cond;
      end
   end

   // A mask written in this cycle already governs the interrupt level,
   // so the line never stays high for a bit that was just masked
   assign next_mask = (WR && ADDR == REG_MASK) ? WDATA[EV_W-1:0] : mask;

   // A new event wins over a write-one-to-clear in the same cycle
   always_comb begin
      next_stat = stat;
      if (WR && ADDR == REG_STAT) begin
         next_stat = stat & ~WDATA[EV_W-1:0];
      end
      next_stat = next_stat | events;
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         stat <= {EV_W{1'b0}};
         IRQ <= 1'b0;
      end else begin
         stat <= next_stat;
         IRQ <= |(next_stat & next_mask);
      end
   end

   // ----------------------------------------------------------------------
   // Tune selection
   // ----------------------------------------------------------------------
   logic [3:0] sync_latched;
   logic read_pulse;
   logic read_axis;

   sync_sampler u_sync (
      .clk (SYS_CLK),
      .rst (RST),
      .sync_in (SYNC_PIN),
      .latched (sync_latched),
      .read_pulse (read_pulse),
      .read_axis (read_axis)
   );

   // Tunes not yet downloaded are refused and the old tune stays
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         TUNE_X <= 4'h0;
         TUNE_Y <= 4'h0;
      end else if (read_pulse && tunes[sync_latched]) begin
         if (read_axis) begin
            TUNE_Y <= sync_latched;
         end else begin
            TUNE_X <= sync_latched;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Indicator
   // ----------------------------------------------------------------------
   logic [31:0] led_cnt;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         led_cnt <= 32'h0;
         LED <= 1'b0;
      end else begin
         if (|events) begin
            led_cnt <= 32'(LED_HOLD);
            LED <= 1'b1;
         end else if (led_cnt > 32'h1) begin
            led_cnt <= led_cnt - 32'h1;
         end else begin
            led_cnt <= 32'h0;
            LED <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------
   always_comb begin
      next_rdata = 32'h0;
      case (ADDR)
         REG_CTRL: next_rdata[4:0] = ctrl;
         REG_STAT: next_rdata[EV_W-1:0] = stat;
         REG_MASK: next_rdata[EV_W-1:0] = mask;
         REG_STATE: begin
            next_rdata[ST_ENABLED +: 2] = enabled;
            next_rdata[ST_FAULT +: 2] = fault;
            next_rdata[ST_HEALTH +: 2] = HEALTH_I;
            next_rdata[ST_READY +: 2] = READY_I;
            next_rdata[ST_SYNC +: 4] = sync_latched;
            next_rdata[ST_TUNE_X +: 4] = TUNE_X;
            next_rdata[ST_TUNE_Y +: 4] = TUNE_Y;
         end
         REG_TUNES: next_rdata[15:0] = tunes;
         default: next_rdata = 32'h0;
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         RDATA <= 32'h0;
      end else if (RD) begin
         RDATA <= next_rdata;
      end else begin
         RDATA <= 32'h0;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   health_pin_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      HEALTH_OE[0] |-> $past(COIL_TEMP_OK[0] && COIL_CUR_OK[0]
         && BOARD_TEMP_OK))
      else $error("X health low while a check failed");
   heater_check_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      (heater_use && !CASE_IN_BAND[1]) |=> !HEALTH_OE[1])
      else $error("Y health low with case out of band");
   ready_pin_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      READY_OE[0] |-> $past(enabled[0] && !fault[0]))
      else $error("X ready low while disabled or faulted");
   board_shut_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      (shutdown_en && board_hot) ##1 (shutdown_en && board_hot)
         |-> !enabled[0] && !enabled[1])
      else $error("board over-temperature did not shut down");
   board_warn_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      $rose(board_hot) |=> stat[EV_BOARD])
      else $error("board warning flag not set");
   ov_trip_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      (CMD_MAG[1] > ov_limit(range)) |-> fault[1])
      else $error("over-voltage did not fault Y");
   tune_keep_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      (read_pulse && !tunes[sync_latched]) |=> $stable(TUNE_X)
         && $stable(TUNE_Y))
      else $error("unloaded pattern changed the active tune");
   led_event_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      (|events) |=> LED [*2])
      else $error("indicator did not light on an event");
   irq_level_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      IRQ |-> |(stat & mask))
      else $error("interrupt high with nothing pending");
   tune_change_c: cover property (@(posedge SYS_CLK) disable iff (RST)
      $changed(TUNE_X) ##[1:400] $changed(TUNE_Y));
   arm_x_c: cover property (@(posedge SYS_CLK) disable iff (RST)
      !ignore_en && EN_PIN[0] ##1 !EN_PIN[0] ##[1:3] READY_OE[0]);
   dl_done_c: cover property (@(posedge SYS_CLK) disable iff (RST)
      dl_pulse ##1 stat[EV_DLDONE] && LED);
endmodule // servo_axis_control_status

// ==== bench/laser_ctrl_model.sv ====
// Laser controller model driving the enable and tune-select pins
`timescale 1ns/1ps
module laser_ctrl_model (
   // Clock
   input wire logic clk,
   // Pins toward the servo driver
   output logic [1:0] en_pin,
   output logic [3:0] sync_pin
);
   // Enable tied low while unused, as an idle controller leaves it
   initial begin
      en_pin = 2'h0;
      sync_pin = 4'h0;
   end

   task automatic set_en(input int ax, input logic v);
      @(posedge clk);
      en_pin[ax] <= v;
   endtask

   // Re-arm after a trip: high for a few cycles, then low again
   task automatic strobe(input int ax);
      set_en(ax, 1'b1);
      repeat (3) @(posedge clk);
      en_pin[ax] <= 1'b0;
   endtask

   task automatic set_sync(input logic [3:0] p);
      @(posedge clk);
      sync_pin <= p;
   endtask
endmodule // laser_ctrl_model

// ==== bench/tb_top.sv ====
// Self-checking testbench for the servo axis control and status block
`timescale 1ns/1ps
module tb_top;
   import servo_pkg::*;
   logic sys_clk, rst, wr, rd, irq, led, board_ok;
   logic [7:0] addr, board_temp;
   logic [31:0] wdata, rdata;
   logic [1:0] en_pin, coil_temp_ok, coil_cur_ok, case_ok, in_band;
   logic [1:0] health_i, health_o, health_oe, ready_i, ready_o, ready_oe;
   logic [3:0] sync_pin, tune_x, tune_y;
   logic [1:0][15:0] cmd_mag;
   logic [15:0] lims [4] = '{OV_MAX_3, OV_MAX_5, OV_MAX_8, OV_MAX_10};
   int err_count = 0;
   int cmp_count = 0;

   // Open-drain lines with pull-ups: low only while a driver enables
   assign health_i = ~health_oe;
   assign ready_i = ~ready_oe;

   initial sys_clk = 1'b0;
   always #20 sys_clk = ~sys_clk;

   servo_axis_control_status #(.LED_HOLD(8)) dut_u (
      .SYS_CLK(sys_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .IRQ(irq), .EN_PIN(en_pin),
      .SYNC_PIN(sync_pin), .COIL_TEMP_OK(coil_temp_ok),
      .COIL_CUR_OK(coil_cur_ok), .CASE_TEMP_OK(case_ok),
      .CASE_IN_BAND(in_band), .BOARD_TEMP_OK(board_ok),
      .BOARD_TEMP(board_temp), .CMD_MAG(cmd_mag), .HEALTH_I(health_i),
      .HEALTH_O(health_o), .HEALTH_OE(health_oe), .READY_I(ready_i),
      .READY_O(ready_o), .READY_OE(ready_oe), .LED(led),
      .TUNE_X(tune_x), .TUNE_Y(tune_y));

   laser_ctrl_model ctrl_u (.clk(sys_clk), .en_pin(en_pin),
      .sync_pin(sync_pin));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Step past the edge so registered outputs have settled
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask

   task automatic rreg(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   function automatic logic [1:0] exp_health(input logic heater);
      exp_health = coil_temp_ok & coil_cur_ok & {2{board_ok}} &
         (heater ? case_ok & in_band : 2'h3);
   endfunction

   // Tests need about 2000 cycles; allow a wide margin
   initial begin
      #1200000;
      err_count++;
      final_report();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] d;
      logic h;
      logic [15:0] map;
      logic [3:0] p, tx;
      int t;
      rst = 1'b1;
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      board_ok = 1'b1;
      board_temp = 8'h19;
      {coil_temp_ok, coil_cur_ok, case_ok, in_band} = 8'hff;
      cmd_mag = '0;
      void'($urandom(27));
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      rreg(REG_CTRL, d);
      check(d, 32'h1);
      rreg(8'h20, d);
      check(d, 32'h0);
      tick(4);
      check(32'(ready_oe), 32'h3);
      repeat (12) begin
         h = 1'($urandom);
         wreg(REG_CTRL, {30'h0, h, 1'b1});
         @(posedge sys_clk);
         {coil_temp_ok, coil_cur_ok, case_ok, in_band} <= 8'($urandom);
         board_ok <= 1'($urandom);
         tick(3);
         check(32'(health_oe), 32'(exp_health(h)));
      end
      @(posedge sys_clk);
      {coil_temp_ok, coil_cur_ok, case_ok, in_band} <= 8'hff;
      board_ok <= 1'b1;
      wreg(REG_CTRL, 32'h0);
      wreg(REG_STAT, 32'hff);
      wreg(REG_MASK, 32'hff);
      ctrl_u.set_en(0, 1'b1);
      ctrl_u.set_en(1, 1'b1);
      tick(3);
      check(32'(ready_oe), 32'h0);
      ctrl_u.set_en(0, 1'b0);
      tick(3);
      check(32'(ready_oe), 32'h1);
      @(posedge sys_clk);
      coil_cur_ok <= 2'h2;
      tick(2);
      check(32'(ready_oe), 32'h0);
      check(32'(irq), 32'h1);
      rreg(REG_STAT, d);
      check(d & 32'h3, 32'h1);
      @(posedge sys_clk);
      coil_cur_ok <= 2'h3;
      tick(4);
      check(32'(ready_oe), 32'h0);
      ctrl_u.strobe(0);
      tick(3);
      check(32'(ready_oe), 32'h1);
      wreg(REG_STAT, 32'h1);
      tick(2);
      check(32'(irq), 32'h0);
      // Warning threshold boundary, then shutdown option
      @(posedge sys_clk);
      board_temp <= BOARD_WARN_C;
      tick(3);
      rreg(REG_STAT, d);
      check(d & 32'h40, 32'h0);
      @(posedge sys_clk);
      board_temp <= BOARD_WARN_C + 8'h01;
      tick(3);
      rreg(REG_STAT, d);
      check(d & 32'h40, 32'h40);
      check(32'(ready_oe), 32'h1);
      wreg(REG_CTRL, 32'h4);
      tick(3);
      check(32'(ready_oe), 32'h0);
      @(posedge sys_clk);
      board_temp <= 8'h19;
      wreg(REG_MASK, 32'h0);
      for (int r = 0; r < 4; r++) begin
         @(posedge sys_clk);
         cmd_mag[1] <= 16'h0;
         wreg(REG_CTRL, 32'(r) << 3);
         wreg(REG_STAT, 32'hff);
         @(posedge sys_clk);
         cmd_mag[1] <= lims[r];
         tick(3);
         rreg(REG_STAT, d);
         check(d & 32'h20, 32'h0);
         @(posedge sys_clk);
         cmd_mag[1] <= lims[r] + 16'h1;
         tick(3);
         rreg(REG_STAT, d);
         check(d & 32'h20, 32'h20);
      end
      check(32'(irq), 32'h0);
      wreg(REG_MASK, 32'hff);
      tick(2);
      check(32'(irq), 32'h1);
      wreg(REG_STAT, 32'hff);
      tick(2);
      check(32'(irq), 32'h0);
      wreg(REG_CTRL, 32'h100);
      tick(3);
      check(32'(led), 32'h1);
      rreg(REG_STAT, d);
      check(d & 32'h80, 32'h80);
      tick(12);
      check(32'(led), 32'h0);
      // ---------------------------------------------------------------
      // Tune selection
      // ---------------------------------------------------------------
      map = 16'h00a0;
      wreg(REG_TUNES, 32'(map));
      // A pattern changing every cycle never looks settled
      fork
         for (int i = 0; i < 30; i++) ctrl_u.set_sync(i[0] ? 4'h1 : 4'h2);
         begin
            tick(20);
            rreg(REG_STATE, d);
            check(d & 32'hf00, 32'h0);
         end
      join
      ctrl_u.set_sync(4'h5);
      t = 0;
      while (tune_x === 4'h0 && tune_y === 4'h0 && t < 400) begin
         tick(1);
         t++;
      end
      t = 0;
      while (!(tune_x === 4'h5 && tune_y === 4'h5) && t < 400) begin
         tick(1);
         t++;
      end
      check(32'(t), 32'(READ_CYC));
      rreg(REG_STATE, d);
      check(d & 32'hf00, 32'h500);
      check(d & 32'hff, 32'hc8);
      check(32'({health_o, ready_o}), 32'h0);
      tx = 4'h5;
      repeat (4) begin
         map = 16'($urandom);
         p = 4'($urandom);
         // Empty map while the pattern settles, so no read can take
         // the old latched pattern under the new map
         wreg(REG_TUNES, 32'h0);
         ctrl_u.set_sync(p);
         tick(12);
         wreg(REG_TUNES, 32'(map));
         tick(2 * READ_CYC + 12);
         if (map[p]) tx = p;
         check(32'(tune_x), 32'(tx));
         check(32'(tune_y), 32'(tx));
      end
      final_report();
   end
endmodule // tb_top
